// >>> verilog/vec_issue_pkg.sv
// Shared types and constants for the vector issue and pipeline control block.
// Assumes a single processor clock and word-wide data supplied by the scalar decoder.
package vec_issue_pkg;

  localparam int WORD_W      = 36;
  localparam int REGS        = 16;
  localparam int REG_IDX_W   = 4;
  localparam int REG_WORDS   = 64;
  localparam int MAX_SP      = 64;
  localparam int MAX_DP      = 32;
  localparam int ELEM_W      = 7;
  localparam int ADDR_W      = 6;
  localparam int PORTS       = 8;
  localparam int BLOCK_WORDS = 4;
  localparam int LB_DEPTH    = 8;
  localparam int LB_PTR_W    = 3;

  localparam logic [ELEM_W-1:0] LIMIT_SP = 7'h40;
  localparam logic [ELEM_W-1:0] LIMIT_DP = 7'h20;
  localparam logic [ELEM_W-1:0] ZERO_LEN = 7'h00;

  typedef enum logic [4:0] {
    OP_ADD   = 5'h00, OP_SUB  = 5'h01, OP_LOGIC = 5'h02, OP_CONV  = 5'h03,
    OP_RED   = 5'h04, OP_CMP  = 5'h05, OP_SHIFT = 5'h06, OP_MUL   = 5'h07,
    OP_PRED  = 5'h08, OP_DIV  = 5'h09, OP_POPC  = 5'h0a, OP_MOVE  = 5'h0b,
    OP_SP2DP = 5'h0c, OP_DP2SP= 5'h0d, OP_CMPR  = 5'h0e, OP_DIST  = 5'h0f,
    OP_PPAR  = 5'h10, OP_LOAD = 5'h11
  } vop_t;

  typedef enum logic [1:0] {
    PIPE_ADD = 2'h0, PIPE_MUL = 2'h1, PIPE_MOV = 2'h2, PIPE_LOAD = 2'h3
  } pipe_t;

  typedef struct packed {
    vop_t                 op;
    logic                 dbl;
    logic [REG_IDX_W-1:0] src_a;
    logic [REG_IDX_W-1:0] src_b;
    logic [REG_IDX_W-1:0] dst;
    logic [ELEM_W-1:0]    len;
  } vinstr_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [2*WORD_W-1:0] data;
  } pair_t;

  typedef struct packed {
    logic [ADDR_W-1:0]        slot;
    logic [BLOCK_WORDS-1:0]   keep;
    logic [BLOCK_WORDS*WORD_W-1:0] data;
  } sblock_t;

endpackage

// >>> verilog/vec_reg_store.sv
// Multi-ported vector register storage with one write and eight read pair ports.
// Assumes the issue controller guarantees one writer per register at a time.
`timescale 1ns/1ps
module vec_reg_store (
  input  wire logic                                  clk,
  input  wire logic                                  we,
  input  wire logic [vec_issue_pkg::REG_IDX_W-1:0]   wreg,
  input  wire vec_issue_pkg::pair_t                  wpair,
  input  wire logic [vec_issue_pkg::REG_IDX_W-1:0]   rreg  [vec_issue_pkg::PORTS],
  input  wire logic [vec_issue_pkg::ADDR_W-1:0]      raddr [vec_issue_pkg::PORTS],
  output logic      [2*vec_issue_pkg::WORD_W-1:0]    rdata [vec_issue_pkg::PORTS]
);

  logic [2*vec_issue_pkg::WORD_W-1:0] mem [vec_issue_pkg::REGS][vec_issue_pkg::REG_WORDS/2];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wreg][wpair.addr[vec_issue_pkg::ADDR_W-1:1]] <= wpair.data;
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < vec_issue_pkg::PORTS; p++) begin
      rdata[p] <= mem[rreg[p]][raddr[p][vec_issue_pkg::ADDR_W-1:1]];
    end
  end

endmodule // vec_reg_store

// >>> verilog/vec_load_buf.sv
// Load buffer taking four-word storage blocks and yielding two-word register writes.
// Assumes the storage side honours blk_ready and the drain side can stall.
`timescale 1ns/1ps
module vec_load_buf (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     blk_valid,
  output logic                          blk_ready,
  input  wire vec_issue_pkg::sblock_t   blk,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output vec_issue_pkg::pair_t          out_pair
);

  vec_issue_pkg::sblock_t              buf_mem [vec_issue_pkg::LB_DEPTH];
  logic [vec_issue_pkg::LB_PTR_W:0]    wptr;
  logic [vec_issue_pkg::LB_PTR_W:0]    rptr;
  logic                                half;
  logic                                full;
  logic                                empty;
  vec_issue_pkg::sblock_t              head;

  assign full      = (wptr ^ rptr) == {1'b1, {vec_issue_pkg::LB_PTR_W{1'b0}}};
  assign empty     = wptr == rptr;
  assign blk_ready = !full;
  assign out_valid = !empty;
  assign head      = buf_mem[rptr[vec_issue_pkg::LB_PTR_W-1:0]];

  always_ff @(posedge clk) begin
    if (blk_valid && !full) begin
      buf_mem[wptr[vec_issue_pkg::LB_PTR_W-1:0]] <= blk;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
    end else if (blk_valid && !full) begin
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr <= '0;
      half <= 1'b0;
    end else if (out_valid && out_ready) begin
      half <= !half;
      if (half) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  // Each block carries its own register slot, so storage addresses need not be consecutive.
  always_comb begin
    out_pair.addr = head.slot + (half ? 6'h02 : 6'h00);
    out_pair.data = half ? head.data[2*vec_issue_pkg::WORD_W-1:0]
                         : head.data[vec_issue_pkg::BLOCK_WORDS*vec_issue_pkg::WORD_W-1:
                                     2*vec_issue_pkg::WORD_W];
  end

endmodule // vec_load_buf

// >>> verilog/vec_issue.sv
// Vector issue and dispatch control: steers instructions to add, multiply and move pipes.
// Assumes the scalar decoder holds INSTR stable while INSTR_VALID is high and not taken.
`timescale 1ns/1ps
module vec_issue (
  input  wire logic                                  REF_CLK,
  input  wire logic                                  RESET_N,
  input  wire logic                                  INSTR_VALID,
  output logic                                       INSTR_READY,
  input  wire vec_issue_pkg::vinstr_t                INSTR,
  output logic                                       LEN_FAULT,
  input  wire logic                                  BLK_VALID,
  output logic                                       BLK_READY,
  input  wire vec_issue_pkg::sblock_t                BLK,
  output logic [2:0]                                 PIPE_BUSY,
  output logic [vec_issue_pkg::PORTS*2*vec_issue_pkg::WORD_W-1:0] OPERANDS
);

  typedef enum logic [2:0] {
    P_IDLE = 3'b001,
    P_RUN  = 3'b010,
    P_DONE = 3'b100
  } pstate_t;

  // Pipe of an opcode.
  function automatic vec_issue_pkg::pipe_t pipe_of(input vec_issue_pkg::vop_t op);
    unique case (op)
      vec_issue_pkg::OP_MUL, vec_issue_pkg::OP_PRED,
      vec_issue_pkg::OP_DIV, vec_issue_pkg::OP_POPC:   pipe_of = vec_issue_pkg::PIPE_MUL;
      vec_issue_pkg::OP_MOVE, vec_issue_pkg::OP_SP2DP, vec_issue_pkg::OP_DP2SP,
      vec_issue_pkg::OP_CMPR, vec_issue_pkg::OP_DIST,
      vec_issue_pkg::OP_PPAR:                          pipe_of = vec_issue_pkg::PIPE_MOV;
      vec_issue_pkg::OP_LOAD:                          pipe_of = vec_issue_pkg::PIPE_LOAD;
      default:                                         pipe_of = vec_issue_pkg::PIPE_ADD;
    endcase
  endfunction

  // Element capacity for the precision.
  function automatic logic [vec_issue_pkg::ELEM_W-1:0] cap_of(input logic dbl);
    cap_of = dbl ? vec_issue_pkg::LIMIT_DP : vec_issue_pkg::LIMIT_SP;
  endfunction

  // Word address of an element.
  function automatic logic [vec_issue_pkg::ADDR_W-1:0] waddr(input logic [vec_issue_pkg::ELEM_W-1:0] e,
                                                             input logic dbl);
    waddr = dbl ? {e[vec_issue_pkg::ADDR_W-2:0], 1'b0} : e[vec_issue_pkg::ADDR_W-1:0];
  endfunction

  pstate_t                               pst     [3];
  vec_issue_pkg::vinstr_t                pins    [3];
  logic [vec_issue_pkg::ELEM_W-1:0]      pidx    [3];
  logic [vec_issue_pkg::ELEM_W-1:0]      written [vec_issue_pkg::REGS];
  logic [vec_issue_pkg::REGS-1:0]        owned;
  logic                                  load_act;
  vec_issue_pkg::vinstr_t                load_ins;
  logic [vec_issue_pkg::ELEM_W-1:0]      load_cnt;
  vec_issue_pkg::pipe_t                  tgt;
  logic                                  pipe_free;
  logic                                  ops_ok;
  logic                                  over;
  logic                                  take;
  logic [2:0]                            step;
  logic [2:0]                            wsel;
  logic                                  we;
  logic [vec_issue_pkg::REG_IDX_W-1:0]   wreg;
  vec_issue_pkg::pair_t                  wpair;
  logic [vec_issue_pkg::REG_IDX_W-1:0]   rreg    [vec_issue_pkg::PORTS];
  logic [vec_issue_pkg::ADDR_W-1:0]      raddr   [vec_issue_pkg::PORTS];
  logic [2*vec_issue_pkg::WORD_W-1:0]    rdata   [vec_issue_pkg::PORTS];
  logic                                  lb_valid;
  logic                                  lb_ready;
  vec_issue_pkg::pair_t                  lb_pair;

  assign tgt  = pipe_of(INSTR.op);
  assign over = INSTR.len > cap_of(INSTR.dbl);

  // Operands are ready once the destination is not claimed by another writer; reads wait per
  // element on the written progress below, so chained use of one register is allowed.
  always_comb begin
    pipe_free = 1'b0;
    unique case (tgt)
      vec_issue_pkg::PIPE_ADD:  pipe_free = pst[0] == P_IDLE;
      vec_issue_pkg::PIPE_MUL:  pipe_free = pst[1] == P_IDLE;
      vec_issue_pkg::PIPE_MOV:  pipe_free = pst[2] == P_IDLE;
      vec_issue_pkg::PIPE_LOAD: pipe_free = !load_act;
    endcase
    ops_ok = !owned[INSTR.dst];
  end

  // In-order issue: only the head instruction is ever considered.
  assign take        = INSTR_VALID && (over || (pipe_free && ops_ok));
  assign INSTR_READY = take;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LEN_FAULT <= 1'b0;
    end else begin
      LEN_FAULT <= INSTR_VALID && over;
    end
  end

  // Per-pipe step: a pipe advances one element when its sources have that element written.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      step[p] = pst[p] == P_RUN &&
                written[pins[p].src_a] > pidx[p] &&
                written[pins[p].src_b] > pidx[p];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int p = 0; p < 3; p++) begin
        pst[p]  <= P_IDLE;
        pins[p] <= '0;
        pidx[p] <= vec_issue_pkg::ZERO_LEN;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        unique case (pst[p])
          P_IDLE: begin
            if (take && !over && tgt == vec_issue_pkg::pipe_t'(p)) begin
              pins[p] <= INSTR;
              pidx[p] <= vec_issue_pkg::ZERO_LEN;
              pst[p]  <= (INSTR.len == vec_issue_pkg::ZERO_LEN) ? P_DONE : P_RUN;
            end
          end
          P_RUN: begin
            if (step[p] && wsel[p]) begin
              pidx[p] <= pidx[p] + 1'b1;
              if (pidx[p] + 1'b1 == pins[p].len) begin
                pst[p] <= P_DONE;
              end
            end
          end
          P_DONE: pst[p] <= P_IDLE;
          default: pst[p] <= P_IDLE;
        endcase
      end
    end
  end

  // One write port per cycle: load buffer first, then add, multiply, move pipes.
  always_comb begin
    wsel  = 3'h0;
    we    = 1'b0;
    wreg  = load_ins.dst;
    wpair = lb_pair;
    if (lb_valid && load_act) begin
      we = 1'b1;
    end else begin
      for (int p = 2; p >= 0; p--) begin
        if (step[p]) begin
          wsel    = 3'h0;
          wsel[p] = 1'b1;
          we      = 1'b1;
          wreg    = pins[p].dst;
          wpair.addr = waddr(pidx[p], pins[p].dbl);
          wpair.data = rdata[2*p] ^ rdata[2*p+1];
        end
      end
    end
  end
  assign lb_ready = load_act;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_act <= 1'b0;
      load_ins <= '0;
      load_cnt <= vec_issue_pkg::ZERO_LEN;
    end else if (take && !over && tgt == vec_issue_pkg::PIPE_LOAD) begin
      load_act <= INSTR.len != vec_issue_pkg::ZERO_LEN;
      load_ins <= INSTR;
      load_cnt <= vec_issue_pkg::ZERO_LEN;
    end else if (load_act && lb_valid) begin
      load_cnt <= load_cnt + 1'b1;
      if (load_cnt + 1'b1 == load_ins.len) begin
        load_act <= 1'b0;
      end
    end
  end

  // Written-element progress; the loaded register stays readable by any number of pipes.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int r = 0; r < vec_issue_pkg::REGS; r++) begin
        written[r] <= vec_issue_pkg::LIMIT_SP;
      end
      owned <= '0;
    end else begin
      // An empty load never completes, so it must not claim its destination.
      if (take && !over &&
          !(tgt == vec_issue_pkg::PIPE_LOAD && INSTR.len == vec_issue_pkg::ZERO_LEN)) begin
        written[INSTR.dst] <= vec_issue_pkg::ZERO_LEN;
        owned[INSTR.dst]   <= 1'b1;
      end
      if (we) begin
        written[wreg] <= written[wreg] + 1'b1;
      end
      for (int p = 0; p < 3; p++) begin
        if (pst[p] == P_DONE) begin
          owned[pins[p].dst]   <= 1'b0;
          written[pins[p].dst] <= cap_of(1'b0);
        end
      end
      if (load_act && lb_valid && load_cnt + 1'b1 == load_ins.len) begin
        owned[load_ins.dst]   <= 1'b0;
        written[load_ins.dst] <= cap_of(1'b0);
      end
    end
  end

  // Each pipe uses two read ports; ports six and seven view the move pipe sources.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      rreg[2*p]    = pins[p].src_a;
      rreg[2*p+1]  = pins[p].src_b;
      raddr[2*p]   = waddr(pidx[p], pins[p].dbl);
      raddr[2*p+1] = waddr(pidx[p], pins[p].dbl);
    end
    rreg[6]  = pins[2].src_a;
    rreg[7]  = pins[2].src_b;
    raddr[6] = waddr(pidx[2], pins[2].dbl);
    raddr[7] = waddr(pidx[2], pins[2].dbl);
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      PIPE_BUSY[p] = pst[p] != P_IDLE;
    end
    for (int k = 0; k < vec_issue_pkg::PORTS; k++) begin
      OPERANDS[k*2*vec_issue_pkg::WORD_W +: 2*vec_issue_pkg::WORD_W] = rdata[k];
    end
  end

  vec_reg_store u_store (
    .clk   (REF_CLK),
    .we    (we),
    .wreg  (wreg),
    .wpair (wpair),
    .rreg  (rreg),
    .raddr (raddr),
    .rdata (rdata)
  );

  vec_load_buf u_lbuf (
    .clk       (REF_CLK),
    .rst_n     (RESET_N),
    .blk_valid (BLK_VALID),
    .blk_ready (BLK_READY),
    .blk       (BLK),
    .out_valid (lb_valid),
    .out_ready (lb_ready),
    .out_pair  (lb_pair)
  );

endmodule // vec_issue

// >>> bench/vec_issue_props.sv
// Checker for the vector issue block, bound to its top-level ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module vec_issue_props (
  input wire logic                   REF_CLK,
  input wire logic                   RESET_N,
  input wire logic                   INSTR_VALID,
  input wire logic                   INSTR_READY,
  input wire vec_issue_pkg::vinstr_t INSTR,
  input wire logic                   LEN_FAULT,
  input wire logic                   BLK_VALID,
  input wire logic                   BLK_READY,
  input wire logic [2:0]             PIPE_BUSY
);
  logic       take;
  logic       over;
  logic       go;
  logic       load_seen;
  logic [1:0] pipe;
  logic [3:0] n_blk;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  assign take = INSTR_VALID && INSTR_READY;
  assign over = INSTR.len > (INSTR.dbl ? vec_issue_pkg::LIMIT_DP : vec_issue_pkg::LIMIT_SP);
  assign go = take && !over && pipe != 2'h3;
  always_comb begin
    if (INSTR.op <= vec_issue_pkg::OP_SHIFT) pipe = 2'h0;
    else if (INSTR.op <= vec_issue_pkg::OP_POPC) pipe = 2'h1;
    else if (INSTR.op <= vec_issue_pkg::OP_PPAR) pipe = 2'h2;
    else pipe = 2'h3;
  end
  // Counts accepted blocks; nothing drains before the first load.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) n_blk <= 4'h0;
    else if (BLK_VALID && BLK_READY && n_blk != 4'hf) n_blk <= n_blk + 4'h1;
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) load_seen <= 1'b0;
    else if (take && INSTR.op == vec_issue_pkg::OP_LOAD) load_seen <= 1'b1;
  end
  chk_add_route: assert property (go && pipe == 2'h0 |=> PIPE_BUSY[0])
    else $error("add class op did not start the add pipe");
  chk_mul_route: assert property (go && pipe == 2'h1 |=> PIPE_BUSY[1])
    else $error("multiply class op did not start the multiply pipe");
  chk_move_route: assert property (go && pipe == 2'h2 |=> PIPE_BUSY[2])
    else $error("move class op did not start the move pipe");
  chk_busy_hold: assert property (INSTR_VALID && !over && pipe != 2'h3 && PIPE_BUSY[pipe] |-> !INSTR_READY)
    else $error("instruction taken while its pipe was busy");
  chk_start_cause: assert property ((PIPE_BUSY & ~$past(PIPE_BUSY)) != 3'h0 |-> $past(go))
    else $error("pipe started without a taken instruction");
  chk_fault_set: assert property (take && over |=> LEN_FAULT)
    else $error("overlong instruction raised no length fault");
  chk_fault_cause: assert property (LEN_FAULT |-> $past(take && over))
    else $error("length fault without an overlong instruction");
  chk_blk_reset: assert property ($rose(RESET_N) |-> BLK_READY)
    else $error("block input not ready after reset");
  chk_blk_room: assert property (!load_seen && n_blk < 4'h8 |-> BLK_READY)
    else $error("block refused with buffer room left");
  chk_blk_full: assert property (!load_seen && n_blk >= 4'h8 |-> !BLK_READY)
    else $error("block input ready with eight blocks held");
endmodule // vec_issue_props

bind vec_issue vec_issue_props u_props (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY),
  .INSTR(INSTR), .LEN_FAULT(LEN_FAULT), .BLK_VALID(BLK_VALID), .BLK_READY(BLK_READY),
  .PIPE_BUSY(PIPE_BUSY)
);

// >>> bench/scalar_feed.sv
// Model of the scalar decoder that offers vector instructions.
// Assumes send is called just after a falling clock edge.
`timescale 1ns/1ps
module scalar_feed (
  input  wire logic              clk,
  input  wire logic              ready,
  output logic                   valid,
  output vec_issue_pkg::vinstr_t instr
);
  initial begin
    valid = 1'b0;
    instr = '0;
  end
  // Holds the offer until taken or for at most 400 cycles, then shows the inverse so stale fields never match.
  // With hold set the offer stays up, so a following call needs no second assignment.
  task automatic send(input vec_issue_pkg::vinstr_t x, output int waited, input bit hold = 1'b0);
    waited = 0;
    valid = 1'b1;
    instr = x;
    #1;
    while (ready !== 1'b1 && waited < 400) begin
      @(negedge clk);
      #1;
      waited++;
    end
    @(posedge clk);
    @(negedge clk);
    if (!hold) begin
      valid = 1'b0;
      instr = vec_issue_pkg::vinstr_t'(~x);
    end
  endtask
endmodule // scalar_feed

// >>> bench/vector_issue_and_pipelines_test.sv
// Self-checking testbench for the vector issue block.
// Assumes the decoder model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module vector_issue_and_pipelines_test;
  logic                   REF_CLK, RESET_N, INSTR_VALID, INSTR_READY, LEN_FAULT;
  logic                   BLK_VALID, BLK_READY, d;
  vec_issue_pkg::vinstr_t INSTR;
  vec_issue_pkg::sblock_t BLK;
  logic [2:0]             PIPE_BUSY;
  logic [575:0]           OPERANDS;
  logic [159:0]           r;
  logic [71:0]            d0;
  int                     miscompares, n_tests, w, i, k, seed;

  vec_issue u_dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID),
    .INSTR_READY(INSTR_READY), .INSTR(INSTR), .LEN_FAULT(LEN_FAULT), .BLK_VALID(BLK_VALID),
    .BLK_READY(BLK_READY), .BLK(BLK), .PIPE_BUSY(PIPE_BUSY), .OPERANDS(OPERANDS));
  scalar_feed u_feed (.clk(REF_CLK), .ready(INSTR_READY), .valid(INSTR_VALID), .instr(INSTR));

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  task cmp(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic int pipe_of(input int op);
    return op < 7 ? 0 : (op < 11 ? 1 : 2);
  endfunction

  function automatic logic [6:0] limit(input logic dbl);
    return dbl ? vec_issue_pkg::LIMIT_DP : vec_issue_pkg::LIMIT_SP;
  endfunction

  function automatic vec_issue_pkg::vinstr_t mk(input int op, input logic dbl,
    input logic [3:0] a, input logic [3:0] dst, input logic [6:0] n);
    mk.op = vec_issue_pkg::vop_t'(op[4:0]);
    mk.dbl = dbl;
    mk.src_a = a;
    mk.src_b = 4'h9;
    mk.dst = dst;
    mk.len = n;
  endfunction

  task wait_idle;
    for (int j = 0; j < 300 && PIPE_BUSY !== 3'h0; j++) @(negedge REF_CLK);
    cmp(PIPE_BUSY === 3'h0, "pipes stay busy");
  endtask

  initial begin
    repeat (20000) @(posedge REF_CLK);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    RESET_N = 1'b0;
    BLK_VALID = 1'b0;
    BLK = '0;
    seed = $urandom(83237);
    repeat (2) @(negedge REF_CLK);
    RESET_N = 1'b1;
    @(negedge REF_CLK);
    cmp(PIPE_BUSY === 3'h0 && BLK_READY === 1'b1 && LEN_FAULT === 1'b0, "reset outputs");
    $display("test reset done");
    for (k = 0; k < 17; k++) begin
      d = 1'($urandom_range(1, 0));
      u_feed.send(mk(k, d, 4'($urandom_range(15, 8)), 4'($urandom_range(7, 0)),
        7'($urandom_range(limit(d), 1))), w);
      cmp(PIPE_BUSY === 3'h1 << pipe_of(k), "wrong pipe started");
      wait_idle;
    end
    $display("test routing done");
    u_feed.send(mk(0, 1'b0, 4'h8, 4'h1, 7'h40), w, 1'b1);
    u_feed.send(mk(7, 1'b0, 4'h8, 4'h2, 7'h40), w);
    cmp(w == 0 && PIPE_BUSY === 3'h3, "back to back issue held");
    u_feed.send(mk(1, 1'b0, 4'h8, 4'h3, 7'h10), w);
    cmp(w > 0, "busy pipe accepted work");
    wait_idle;
    u_feed.send(mk(0, 1'b1, 4'h8, 4'h4, 7'h20), w, 1'b1);
    u_feed.send(mk(11, 1'b1, 4'h4, 4'h5, 7'h20), w);
    cmp(w == 0 && PIPE_BUSY === 3'h5, "dependent op held");
    wait_idle;
    $display("test order done");
    for (i = 0; i < 4; i++) begin
      u_feed.send(mk(2, i[0], 4'h8, 4'h6, limit(i[0]) + 7'(i[1])), w);
      cmp(LEN_FAULT === i[1], "length fault wrong");
      wait_idle;
    end
    $display("test length done");
    for (i = 0; i < 9; i++) begin
      r = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
      BLK.slot = 6'(i * 8);
      if (i == 0) d0 = r[143:72];
      BLK.keep = 4'hf;
      BLK.data = r[143:0];
      BLK_VALID = 1'b1;
      #1;
      cmp(BLK_READY === (i < 8), "block ready wrong");
      @(negedge REF_CLK);
    end
    BLK_VALID = 1'b0;
    BLK = vec_issue_pkg::sblock_t'(~BLK);
    u_feed.send(mk(17, 1'b0, 4'h8, 4'h7, 7'h10), w);
    for (i = 0; i < 100 && BLK_READY !== 1'b1; i++) @(negedge REF_CLK);
    cmp(BLK_READY === 1'b1, "load did not drain buffer");
    u_feed.send(mk(11, 1'b0, 4'h7, 4'h0, 7'h01), w);
    wait_idle;
    cmp(OPERANDS[4*72 +: 72] === d0 && OPERANDS[6*72 +: 72] === d0, "loaded pair not read");
    $display("test buffer done");
    give_verdict;
  end
endmodule // vector_issue_and_pipelines_test
